// [verilog/asrp_pkg.sv]
// Purpose: Shared constants for the converter serial register port.
// Assumes: The system clock samples the slow serial link clock.
// Notes:   Register selection follows a three-bit field of the control word.
package asrp_pkg;
    // Field positions inside the communications (control) word.
    localparam int unsigned CW_READY_BIT = 7;   // Data-ready status bit when read back.
    localparam int unsigned CW_RS_HI     = 6;   // Register select, high bit.
    localparam int unsigned CW_RS_LO     = 4;   // Register select, low bit.
    localparam int unsigned CW_RW_BIT    = 3;   // One selects a read transfer.
    localparam int unsigned CW_ZERO_BIT  = 7;   // Must be zero on a write.
    // Register select codes.
    localparam logic [2:0] RS_COMM   = 3'h0;    // Communications register.
    localparam logic [2:0] RS_SETUP  = 3'h1;    // Setup register.
    localparam logic [2:0] RS_CLOCK  = 3'h2;    // Clock register.
    localparam logic [2:0] RS_DATA   = 3'h3;    // Output data register, 16 bits.
    localparam logic [2:0] RS_TEST   = 3'h4;    // Test register.
    localparam logic [2:0] RS_OFFSET = 3'h6;    // Offset register, 24 bits.
    localparam logic [2:0] RS_GAIN   = 3'h7;    // Gain register, 24 bits.
    // Transfer lengths in serial clocks.
    localparam logic [4:0] LEN_BYTE  = 5'h08;
    localparam logic [4:0] LEN_DATA  = 5'h10;
    localparam logic [4:0] LEN_WIDE  = 5'h18;
    // Run of ones that resets the interface.
    localparam logic [5:0] ONES_RESET = 6'h20;
    // Reset values.
    localparam logic [7:0]  SETUP_RESET  = 8'h01;
    localparam logic [7:0]  CLOCK_RESET  = 8'h05;
    localparam logic [7:0]  TEST_RESET   = 8'h00;
    localparam logic [23:0] OFFSET_RESET = 24'h800000;
    localparam logic [23:0] GAIN_RESET   = 24'h5761ab;
    // Conversion FIFO shape.
    localparam int unsigned FIFO_WIDTH = 16;
    localparam int unsigned FIFO_DEPTH = 8;
    // Bench link clock and system clock, for reference counts.
    localparam int unsigned SYS_PERIOD_PS  = 4000;
    localparam int unsigned LINK_PERIOD_PS = 160000;
    // Cycles data-ready stays high before an update of the output register.
    localparam int unsigned UPD_GAP_NS  = 40;
    localparam logic [3:0]  UPD_GAP_CYC = 4'((UPD_GAP_NS * 1000 + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS);
    // Port state machine, one-hot.
    typedef enum logic [2:0] {
        ST_CMD   = 3'b001,   // Awaiting a control word.
        ST_WRITE = 3'b010,   // Shifting in a register write.
        ST_READ  = 3'b100    // Shifting out a register read.
    } asrp_state_t;
endpackage

// [verilog/asrp_sync.sv]
// Purpose: Two flip-flop synchroniser for one pin input.
// Assumes: The input is asynchronous to clk_sys.
// Notes:   The first stage is read by the second stage only.
`timescale 1ns/1ps
module asrp_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    input  wire logic pin,
    output logic      level
);
    logic meta;   // First stage, possibly metastable.

    // Two-stage capture of the pin.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            meta  <= RESET_VAL;
            level <= RESET_VAL;
        end else begin
            meta  <= pin;
            level <= meta;
        end
    end
endmodule

// [verilog/asrp_fifo.sv]
// Purpose: Small synchronous FIFO for conversion words.
// Assumes: One clock; push and pop may coincide.
// Notes:   Full and empty are exact; ready drops when full.
`timescale 1ns/1ps
module asrp_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];    // Word storage.
    logic [AW-1:0]    wr_ptr;         // Next slot to fill.
    logic [AW-1:0]    rd_ptr;         // Oldest word.
    logic [AW:0]      count;          // Words held.
    wire              push = in_valid && in_ready;
    wire              pop  = out_valid && out_ready;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    // Storage write; no reset needed for the array.
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill level.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// [verilog/asrp_port.sv]
// Purpose: Serial register port of a multi-channel sigma-delta converter.
// Assumes: Host drives serial clock and chip select; clk_sys oversamples them.
// Notes:   Conversion words arrive on a stream input and pass an 8-word FIFO.
//
// Contract
// - Reset leaves port awaiting a control word.
// - Control word picks direction and target register.
// - Data in on input, out on output, clocked.
// - Data-ready low when fresh word is loaded.
// - Data-ready high after data register read completes.
// - Data-ready rises before output register update.
// - Chip select gates all serial participation.
// - Same word may be read again.
// - Three-wire: data-ready is control word MSB.
// - Chip select fall presents output MSB.
// - Free-running serial clock is tolerated.
// - Device reset returns interface to idle.
// - Thirty-two ones in a row reset interface.
// - Ones reset keeps all register contents.
// - Works with input and output tied together.
// - Half duplex: writes silent, reads ignore input.
// - Words travel most significant bit first.
// - Control word followed at once by selected transfer.
// - Data 16, offset/gain 24, others 8 clocks.
`timescale 1ns/1ps
module asrp_port (
    input  wire logic        clk_sys,       // System clock, 250 MHz.
    input  wire logic        rst_b,         // Synchronous reset, active low.
    input  wire logic        sclk,          // Host serial clock pin.
    input  wire logic        cs_n,          // Chip select pin, active low.
    input  wire logic        sdi,           // Serial data in pin.
    output logic             sdo,           // Serial data out value.
    output logic             sdo_oe,        // Serial out enable, high while driving.
    output logic             data_ready_n,  // Data-ready output, active low.
    input  wire logic        conv_valid,    // New conversion word offered.
    output logic             conv_ready,    // FIFO can take a word.
    input  wire logic [15:0] conv_data,     // Conversion word.
    output logic [7:0]       setup_reg,     // Setup register contents.
    output logic [7:0]       clock_reg,     // Clock register contents.
    output logic [7:0]       test_reg,      // Test register contents.
    output logic [23:0]      offset_reg,    // Offset register contents.
    output logic [23:0]      gain_reg       // Gain register contents.
);
    // Synchronised pins.
    logic sclk_s;                  // Serial clock, synchronised.
    logic cs_n_s;                  // Chip select, synchronised.
    logic sdi_s;                   // Serial input, synchronised.
    logic sclk_d;                  // Serial clock, one cycle late.
    logic cs_n_d;                  // Chip select, one cycle late.

    // Port state.
    asrp_pkg::asrp_state_t state;  // Current transfer phase.
    logic [2:0]  sel;              // Register chosen by the last control word.
    logic [4:0]  bit_cnt;          // Bits done in this transfer.
    logic [23:0] shreg;            // Shift register for both directions.
    logic [5:0]  ones_cnt;         // Consecutive ones seen on the input.
    logic [7:0]  comm_low;         // Stored low bits of the control word.
    logic [15:0] out_word;         // Output data register.
    logic        data_read_done;   // Pulse: a data register read finished.

    // Update sequencing from the FIFO.
    logic [3:0]  gap_cnt;          // Cycles data-ready has been held high before update.
    logic        updating;         // An update is in progress.

    // Each pin passes two flip-flops before any logic reads it.
    asrp_sync #(.RESET_VAL(1'b1)) u_sync_sclk (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pin     (sclk),
        .level   (sclk_s)
    );
    asrp_sync #(.RESET_VAL(1'b1)) u_sync_cs (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pin     (cs_n),
        .level   (cs_n_s)
    );
    asrp_sync #(.RESET_VAL(1'b0)) u_sync_sdi (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .pin     (sdi),
        .level   (sdi_s)
    );

    // FIFO between the conversion stream and the output data register.
    logic        fifo_valid;       // A buffered word waits.
    logic [15:0] fifo_data;        // Oldest buffered word.
    wire         fifo_pop;         // Take the word into the output register.
    asrp_fifo #(
        .WIDTH (asrp_pkg::FIFO_WIDTH),
        .DEPTH (asrp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .in_valid  (conv_valid),
        .in_ready  (conv_ready),
        .in_data   (conv_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // Edge detection on the synchronised pins.
    wire selected  = !cs_n_s;
    wire rise      = sclk_s && !sclk_d && selected;
    wire fall      = !sclk_s && sclk_d && selected;
    wire cs_fall   = !cs_n_s && cs_n_d;
    wire cs_rise   = cs_n_s && !cs_n_d;

    // Transfer length for the selected register.
    wire [4:0] sel_len = (sel == asrp_pkg::RS_DATA) ? asrp_pkg::LEN_DATA :
                         (sel == asrp_pkg::RS_OFFSET || sel == asrp_pkg::RS_GAIN) ? asrp_pkg::LEN_WIDE :
                         asrp_pkg::LEN_BYTE;
    wire [4:0] cur_len = (state == asrp_pkg::ST_CMD) ? asrp_pkg::LEN_BYTE : sel_len;
    wire       last    = rise && (bit_cnt == cur_len - 5'h01);
    wire [23:0] shin   = {shreg[22:0], sdi_s};

    // Control word value as read back, with live data-ready in the MSB.
    wire [7:0] comm_rd = {data_ready_n, comm_low[6:0]};

    // Read image of the selected register, MSB aligned to bit 23.
    wire [23:0] rd_img = (sel == asrp_pkg::RS_COMM)   ? {comm_rd, 16'h0000} :
                         (sel == asrp_pkg::RS_SETUP)  ? {setup_reg, 16'h0000} :
                         (sel == asrp_pkg::RS_CLOCK)  ? {clock_reg, 16'h0000} :
                         (sel == asrp_pkg::RS_DATA)   ? {out_word, 8'h00} :
                         (sel == asrp_pkg::RS_TEST)   ? {test_reg, 16'h0000} :
                         (sel == asrp_pkg::RS_OFFSET) ? offset_reg :
                         (sel == asrp_pkg::RS_GAIN)   ? gain_reg : 24'h000000;

    // Decoded control word at the end of a command transfer.
    wire [7:0] cw       = shin[7:0];
    wire       cw_read  = cw[asrp_pkg::CW_RW_BIT];
    wire [2:0] cw_sel   = cw[asrp_pkg::CW_RS_HI:asrp_pkg::CW_RS_LO];
    wire       ones_hit = rise && sdi_s && (ones_cnt == asrp_pkg::ONES_RESET - 6'h01);

    assign data_read_done = last && (state == asrp_pkg::ST_READ) && (sel == asrp_pkg::RS_DATA);
    assign fifo_pop       = updating && (gap_cnt == asrp_pkg::UPD_GAP_CYC) &&
                            !(state == asrp_pkg::ST_READ && sel == asrp_pkg::RS_DATA);

    // Pin history for edge finding.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sclk_d <= 1'b1;
            cs_n_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
        end
    end

    // Run-of-ones counter; any zero or deselect restarts it.
    always_ff @(posedge clk_sys) begin
        if (!rst_b || cs_n_s) begin
            ones_cnt <= 6'h00;
        end else if (rise) begin
            ones_cnt <= (sdi_s && !ones_hit) ? ones_cnt + 6'h01 : 6'h00;
        end
    end

    // Transfer state machine; a free-running clock just keeps shifting.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state   <= asrp_pkg::ST_CMD;
            sel     <= asrp_pkg::RS_COMM;
            bit_cnt <= 5'h00;
        end else if (ones_hit) begin
            state   <= asrp_pkg::ST_CMD;
            bit_cnt <= 5'h00;
        end else if (cs_rise) begin
            bit_cnt <= 5'h00;
        end else if (last) begin
            bit_cnt <= 5'h00;
            unique case (state)
                asrp_pkg::ST_CMD: begin
                    // Zero MSB marks a genuine control word; otherwise stay put.
                    if (!cw[asrp_pkg::CW_ZERO_BIT]) begin
                        sel   <= cw_sel;
                        state <= cw_read ? asrp_pkg::ST_READ : asrp_pkg::ST_WRITE;
                    end
                end
                asrp_pkg::ST_WRITE: begin
                    state <= asrp_pkg::ST_CMD;
                end
                asrp_pkg::ST_READ: begin
                    state <= asrp_pkg::ST_CMD;
                end
            endcase
        end else if (rise) begin
            bit_cnt <= bit_cnt + 5'h01;
        end
    end

    // Shift register: loads the read image, shifts out on falling edges.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            shreg <= 24'h000000;
        end else if (last && state == asrp_pkg::ST_CMD && cw_read && !cw[asrp_pkg::CW_ZERO_BIT]) begin
            shreg <= 24'h000000;                              // Reloaded below once sel settles.
        end else if ((state == asrp_pkg::ST_READ) && (bit_cnt == 5'h00 || cs_fall) && !fall) begin
            shreg <= rd_img;
        end else if (state == asrp_pkg::ST_READ && fall) begin
            shreg <= {shreg[22:0], 1'b0};
        end else if (state != asrp_pkg::ST_READ && rise) begin
            shreg <= shin;
        end
    end

    // Serial output: driven only while selected in a read transfer.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sdo    <= 1'b1;
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= selected && (state == asrp_pkg::ST_READ);
            sdo    <= shreg[23];
        end
    end

    // Register writes at the end of a write transfer; the ones reset bypasses this.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            comm_low   <= 8'h00;
            setup_reg  <= asrp_pkg::SETUP_RESET;
            clock_reg  <= asrp_pkg::CLOCK_RESET;
            test_reg   <= asrp_pkg::TEST_RESET;
            offset_reg <= asrp_pkg::OFFSET_RESET;
            gain_reg   <= asrp_pkg::GAIN_RESET;
        end else if (last && !ones_hit) begin
            if (state == asrp_pkg::ST_CMD && !cw[asrp_pkg::CW_ZERO_BIT]) begin
                comm_low <= cw;
            end else if (state == asrp_pkg::ST_WRITE) begin
                unique case (sel)
                    asrp_pkg::RS_SETUP:  setup_reg  <= shin[7:0];
                    asrp_pkg::RS_CLOCK:  clock_reg  <= shin[7:0];
                    asrp_pkg::RS_TEST:   test_reg   <= shin[7:0];
                    asrp_pkg::RS_OFFSET: offset_reg <= shin;
                    asrp_pkg::RS_GAIN:   gain_reg   <= shin;
                    default:             comm_low   <= comm_low;   // Read-only targets ignore data.
                endcase
            end
        end
    end

    // Output update: raise data-ready, hold it, then load the new word.
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            updating     <= 1'b0;
            gap_cnt      <= 4'h0;
            out_word     <= 16'h0000;
            data_ready_n <= 1'b1;
        end else if (fifo_pop) begin
            updating     <= 1'b0;
            gap_cnt      <= 4'h0;
            out_word     <= fifo_data;
            data_ready_n <= 1'b0;
        end else if (updating) begin
            data_ready_n <= 1'b1;
            if (gap_cnt != asrp_pkg::UPD_GAP_CYC) begin
                gap_cnt <= gap_cnt + 4'h1;
            end
        end else if (fifo_valid) begin
            updating     <= 1'b1;
            data_ready_n <= 1'b1;
        end else if (data_read_done) begin
            data_ready_n <= 1'b1;
        end
    end
endmodule

// [tb/asrp_chk.sv]
// Purpose: Port checker for the serial register port.
// Assumes: Pin effects lag the serial pins by a few system clocks.
// Notes:   Bound to the port module at the foot of this file.
`timescale 1ns/1ps
module asrp_chk (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic        sdo,
    input wire logic        sdo_oe,
    input wire logic        data_ready_n,
    input wire logic [7:0]  setup_reg,
    input wire logic [7:0]  clock_reg,
    input wire logic [7:0]  test_reg,
    input wire logic [23:0] offset_reg,
    input wire logic [23:0] gain_reg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Deselected for a while means the output is released.
    property p_oe_idle; cs_n [*5] |-> !sdo_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("sdo_oe high while deselected");
    // A rising chip select abandons a read within a few clocks.
    property p_oe_drop; $rose(cs_n) |-> ##[1:6] !sdo_oe; endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("read not abandoned on deselect");
    // The output only starts driving for a selected device.
    property p_oe_sel; $rose(sdo_oe) |-> !$past(cs_n, 3); endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("sdo_oe rose while deselected");
    // Within a read, output bits move only after a falling serial clock.
    property p_sdo_edge; sdo_oe && $past(sdo_oe, 4) && $changed(sdo) |-> !$past(sclk, 2) || !$past(sclk, 4); endproperty
    a_sdo_edge: assert property (p_sdo_edge) else $error("sdo changed away from a falling edge");
    // Data-ready is high two and nine cycles before it falls, inside the update gap.
    property p_rdy_gap; $fell(data_ready_n) |-> $past(data_ready_n, 2) && $past(data_ready_n, 9); endproperty
    a_rdy_gap: assert property (p_rdy_gap) else $error("data ready fell without update gap");
    // Nothing is written while the device is deselected.
    property p_regs_idle; cs_n [*6] |-> $stable({setup_reg, clock_reg, test_reg, offset_reg, gain_reg}); endproperty
    a_regs_idle: assert property (p_regs_idle) else $error("register changed while deselected");
    // Input bits are ignored while a read drives the output.
    property p_regs_read; sdo_oe |-> $stable({setup_reg, clock_reg, test_reg, offset_reg, gain_reg}); endproperty
    a_regs_read: assert property (p_regs_read) else $error("register changed during a read");
    // Leaving reset finds the port idle with no word ready.
    property p_rst_idle; $rose(rst_b) |-> !sdo_oe && data_ready_n; endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("port not idle after reset");
endmodule
bind asrp_port asrp_chk i_asrp_chk (.clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n), .sdo(sdo),
    .sdo_oe(sdo_oe), .data_ready_n(data_ready_n), .setup_reg(setup_reg), .clock_reg(clock_reg),
    .test_reg(test_reg), .offset_reg(offset_reg), .gain_reg(gain_reg));

// [tb/asrp_host.sv]
// Purpose: Host serial master that drives the port's pins.
// Assumes: Half period of the serial clock is 20 system clocks, 160 ns in all.
// Notes:   The shared data line is pulled up, so a released output reads as one.
`timescale 1ns/1ps
module asrp_host (
    input  wire logic clk_sys,
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    logic keep_low;  // Holds chip select low for three-wire use.
    // Serial clock rests high between frames.
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi = 1'b1;
        keep_low = 1'b0;
    end
    // Waits a number of system clocks at the falling edge.
    task automatic wait_cyc(input int c);
        repeat (c) @(negedge clk_sys);
    endtask
    // Runs one framed burst, most significant bit first.
    task automatic xfer(input int n, input logic [31:0] wv, output logic [31:0] rv);
        rv = '0;
        @(negedge clk_sys);
        cs_n = 1'b0;
        wait_cyc(20);
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b0;
            sdi = wv[i];
            wait_cyc(20);
            sclk = 1'b1;
            rv[i] = sdo_oe ? sdo : 1'b1;
            wait_cyc(20);
        end
        if (!keep_low) begin
            cs_n = 1'b1;
        end
        sdi = ~sdi;  // Released line shows no stale bit.
        wait_cyc(20);
    endtask
endmodule

// [tb/tb.sv]
// Purpose: Self-checking bench for the serial register port.
// Assumes: The host model drives the pins; the bench drives the stream.
// Notes:   A register image by select code is the reference model.
`timescale 1ns/1ps
module tb;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        sclk, cs_n, sdi, sdo, sdo_oe, data_ready_n, conv_ready;
    logic        conv_valid = 1'b0;
    logic [15:0] conv_data = '0;
    logic [7:0]  setup_reg, clock_reg, test_reg;
    logic [23:0] offset_reg, gain_reg;
    logic [23:0] mdl [8];    // Expected contents by select code.
    logic [31:0] rv;         // Last word read by the host.
    logic [15:0] last_word;  // Last conversion word accepted.
    int          err_count = 0;
    int          cmp_count = 0;
    always #2 clk_sys = ~clk_sys;
    asrp_port i_asrp_port (.clk_sys(clk_sys), .rst_b(rst_b), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .data_ready_n(data_ready_n), .conv_valid(conv_valid), .conv_ready(conv_ready),
        .conv_data(conv_data), .setup_reg(setup_reg), .clock_reg(clock_reg), .test_reg(test_reg),
        .offset_reg(offset_reg), .gain_reg(gain_reg));
    asrp_host i_asrp_host (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
    // Prints the counts and the verdict, then stops.
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Compares one value and reports a mismatch.
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Transfer length by select code.
    function automatic int len(input logic [2:0] sel);
        return (sel == asrp_pkg::RS_DATA) ? 16 : ((sel >= asrp_pkg::RS_OFFSET) ? 24 : 8);
    endfunction
    // Control word then data as one burst; the image follows the write.
    task automatic wr(input logic [2:0] sel, input logic [23:0] v);
        i_asrp_host.xfer(8 + len(sel), (32'({1'b0, sel, 4'h0}) << len(sel)) | 32'(v), rv);
        mdl[sel] = v;
    endtask
    // Control word then a read with noise on the input line.
    task automatic rd(input logic [2:0] sel);
        i_asrp_host.xfer(8 + len(sel), (32'({1'b0, sel, 4'h8}) << len(sel)) | ($urandom & 32'hff), rv);
        rv = rv & ((32'h1 << len(sel)) - 32'h1);  // Control word bits read as the pull-up level.
    endtask
    // Checks every register output against the image.
    task automatic chk_regs();
        check("setup_reg", mdl[1], 24'(setup_reg));
        check("clock_reg", mdl[2], 24'(clock_reg));
        check("test_reg", mdl[4], 24'(test_reg));
        check("offset_reg", mdl[6], offset_reg);
        check("gain_reg", mdl[7], gain_reg);
    endtask
    // Resets the device and the image.
    task automatic do_reset();
        rst_b = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        mdl[1] = 24'(asrp_pkg::SETUP_RESET);
        mdl[2] = 24'(asrp_pkg::CLOCK_RESET);
        mdl[4] = 24'(asrp_pkg::TEST_RESET);
        mdl[6] = asrp_pkg::OFFSET_RESET;
        mdl[7] = asrp_pkg::GAIN_RESET;
        repeat (4) @(negedge clk_sys);
    endtask
    // Bounded wait for a data-ready level.
    task automatic wait_rdy(input logic lvl);
        for (int i = 0; i < 400 && data_ready_n !== lvl; i++) begin
            @(negedge clk_sys);
        end
        check("data_ready_n", 24'(lvl), 24'(data_ready_n));
        if (data_ready_n !== lvl) begin
            complete_run();
        end
    endtask
    // Offers words back to back; returns how many were taken.
    task automatic push(input int n, output int taken);
        taken = 0;
        for (int i = 0; i < n; i++) begin
            conv_valid = 1'b1;
            conv_data = 16'($urandom);
            if (conv_ready) begin
                taken++;
                last_word = conv_data;
            end
            @(negedge clk_sys);
        end
        conv_valid = 1'b0;
    endtask
    logic [2:0] sels [5] = '{3'h1, 3'h2, 3'h4, 3'h6, 3'h7};
    int         k;
    // Main sequence.
    initial begin
        void'($urandom(32'h5e5f));
        do_reset();
        chk_regs();
        $display("test reset values done");
        foreach (sels[i]) wr(sels[i], 24'($urandom) & ((24'h1 << len(sels[i])) - 24'h1));
        chk_regs();
        foreach (sels[i]) begin
            rd(sels[i]);
            check("read back", mdl[sels[i]], rv[23:0]);
        end
        $display("test register access done");
        i_asrp_host.xfer(4, 32'h0, rv);
        wr(asrp_pkg::RS_TEST, 24'h5a);
        chk_regs();
        $display("test abort done");
        push(1, k);
        wait_rdy(1'b0);
        rd(asrp_pkg::RS_DATA);
        check("data word", 24'(last_word), rv[23:0]);
        check("data_ready_n", 24'h1, 24'(data_ready_n));
        rd(asrp_pkg::RS_DATA);
        check("data again", 24'(last_word), rv[23:0]);
        i_asrp_host.keep_low = 1'b1;
        rd(asrp_pkg::RS_COMM);
        check("status bit", 24'h1, 24'(rv[7]));
        push(1, k);
        wait_rdy(1'b0);
        rd(asrp_pkg::RS_COMM);
        check("status bit", 24'h0, 24'(rv[7]));
        i_asrp_host.keep_low = 1'b0;
        $display("test data path done");
        push(12, k);
        check("refused", 24'h1, 24'(k < 12));
        repeat (300) @(negedge clk_sys);
        check("conv_ready", 24'h1, 24'(conv_ready));
        wait_rdy(1'b0);
        rd(asrp_pkg::RS_DATA);
        check("newest word", 24'(last_word), rv[23:0]);
        $display("test buffer done");
        i_asrp_host.xfer(8, 32'h10, rv);
        do_reset();
        wr(asrp_pkg::RS_CLOCK, 24'h0c);
        chk_regs();
        $display("test mid-run reset done");
        i_asrp_host.xfer(32, 32'h68ffffff, rv);
        check("offset read", mdl[6], rv[23:0]);
        i_asrp_host.xfer(32, 32'hffffffff, rv);
        chk_regs();
        wr(asrp_pkg::RS_SETUP, 24'h3c);
        chk_regs();
        $display("test recovery done");
        complete_run();
    end
endmodule
